/* shared/lcd_timing_pkg.sv */
`default_nettype none
package lcd_timing_pkg;
    // multiplex duty codes
    localparam logic [1:0] DUTY_STATIC  = 2'h0;
    localparam logic [1:0] DUTY_THIRD   = 2'h1;
    localparam logic [1:0] DUTY_QUARTER = 2'h2;
    // reference divide ratio = 2^(BASE_DIV_LOG2_MIN + select)
    localparam int         BASE_DIV_LOG2_MIN = 7;
    localparam int         DIV_W             = 14;
    // fast charge pulse = base period >> (5 + select)
    localparam int         CHARGE_SHIFT_MIN  = 5;
    localparam logic [1:0] CHARGE_SEL_UNUSED = 2'h3;
    localparam int         NUM_FRONT         = 33;
    localparam int         NUM_PLANE_LEVELS  = 4;
    // plane drive level codes: 0=vdd/vlcd,1=vlcd1,2=vlcd2,3=vlcd3
    localparam logic [1:0] LVL_VLCD  = 2'h0;
    localparam logic [1:0] LVL_VLCD1 = 2'h1;
    localparam logic [1:0] LVL_VLCD2 = 2'h2;
    localparam logic [1:0] LVL_VLCD3 = 2'h3;
    localparam logic [1:0] LADDER_OFF  = 2'h0;
    localparam logic [1:0] LADDER_LOWR = 2'h1;
    localparam logic [1:0] LADDER_HIGHR = 2'h2;
    localparam logic [3:0] CONTRAST_RESET = 4'h0;
endpackage
`default_nettype wire

/* src/lcd_segment_waveform_timing.sv */
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - static duty drives only backplane zero
// - quarter duty drives all four backplanes
// - enabled driver outputs selected-duty backplane waveforms
// - base clock divides reference by select field
// - plane waveforms step on base clock only
// - frame spans two, six or eight periods
// - low current selects high-resistance ladder
// - fast charge pulses low resistance per edge
// - pulse width base/32, /64 or /128
// - four-bit contrast sets lowest bias level
// - wait mode leaves waveforms unchanged
// - stop with oscillator keep keeps running
// - stop without keep halts, keeps settings
// - external interrupt wake resumes waveforms
// - thirty-six outputs, sixteen shared with ports
// - shared pin is backplane three in quarter
// - frontplane waveform from duty and segment bits
// - one bit gives frontplanes 11-18 to port
// - two bits give frontplanes 19-26 to port
// - segment bit one turns segment on
// - disabled driver holds planes at supply, ladder off
module lcd_segment_waveform_timing
    import lcd_timing_pkg::*;
(
    input  wire logic                  sys_clk_i,
    input  wire logic                  rstn_i,
    input  wire logic                  ref_tick_i,
    input  wire logic                  display_driver_on_i,
    input  wire logic [1:0]            duty_select_i,
    input  wire logic [2:0]            base_divider_select_i,
    input  wire logic                  low_current_select_i,
    input  wire logic                  fast_charge_select_i,
    input  wire logic [1:0]            charge_pulse_width_select_i,
    input  wire logic [3:0]            contrast_step_select_i,
    input  wire logic                  standby_oscillator_keep_i,
    input  wire logic                  stop_mode_i,
    input  wire logic                  wake_interrupt_i,
    input  wire logic                  porte_display_select_i,
    input  wire logic                  portc_low_display_select_i,
    input  wire logic                  portc_high_display_select_i,
    input  wire logic [4*NUM_FRONT-1:0] segment_bit_i,
    output logic [1:0]                 backplane_out_0_o,
    output logic [1:0]                 backplane_out_1_o,
    output logic [1:0]                 backplane_out_2_o,
    output logic [1:0]                 shared_plane_pin_o,
    output logic [2*NUM_FRONT-1:0]     frontplane_outputs_o,
    output logic [NUM_FRONT-1:0]       frontplane_port_mode_o,
    output logic [1:0]                 ladder_select_o,
    output logic [3:0]                 contrast_level_o,
    output logic                       base_tick_o,
    output logic                       charge_pulse_o
);

    ////////////////////////////////////////////////////////////////////////
    // run gating: stop without oscillator keep freezes divider, phase and charge count
    logic halted_ff;
    logic run;

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            halted_ff <= 1'b0;
        end else if (wake_interrupt_i) begin
            halted_ff <= 1'b0;
        end else if (stop_mode_i && !standby_oscillator_keep_i) begin
            halted_ff <= 1'b1;
        end
    end

    // wait mode is not an input at all: nothing changes in it
    assign run = display_driver_on_i && !halted_ff && ref_tick_i;

    ////////////////////////////////////////////////////////////////////////
    // base clock divider on reference ticks
    logic [DIV_W-1:0] div_cnt_ff;
    logic [DIV_W-1:0] div_last;
    logic [DIV_W-1:0] nxt_div_cnt;
    logic             base_tick;
    logic [DIV_W-1:0] charge_len;

    assign div_last = DIV_W'((1 << (BASE_DIV_LOG2_MIN
                      + int'(base_divider_select_i))) - 1);
    assign base_tick = run && (div_cnt_ff >= div_last);
    assign nxt_div_cnt = base_tick ? '0 : div_cnt_ff + 1'b1;

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            div_cnt_ff <= '0;
        end else if (!display_driver_on_i) begin
            div_cnt_ff <= '0;
        end else if (run) begin
            div_cnt_ff <= nxt_div_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // phase: half of the backplane step (one base period each) and backplane step within frame
    logic       half_ff;
    logic [1:0] phase_ff;
    logic [1:0] phase_last;

    always_comb begin
        unique case (duty_select_i)
            DUTY_THIRD:   phase_last = 2'h2;
            DUTY_QUARTER: phase_last = 2'h3;
            default:      phase_last = 2'h0;
        endcase
    end

    // frame = 2*(phase_last+1) base periods
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            phase_ff <= 2'h0;
            half_ff  <= 1'b0;
        end else if (!display_driver_on_i) begin
            phase_ff <= 2'h0;
            half_ff  <= 1'b0;
        end else if (base_tick) begin
            half_ff <= ~half_ff;
            if (half_ff) begin
                phase_ff <= (phase_ff >= phase_last) ? 2'h0
                                                     : phase_ff + 2'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // fast charge pulse after each waveform edge
    logic [DIV_W-1:0] charge_cnt_ff;

    // base period divided by 32/64/128
    assign charge_len = DIV_W'((1 << (BASE_DIV_LOG2_MIN
                        + int'(base_divider_select_i)))
                        >> (CHARGE_SHIFT_MIN
                        + int'(charge_pulse_width_select_i)));

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            charge_cnt_ff <= '0;
        end else if (!display_driver_on_i) begin
            charge_cnt_ff <= '0;
        end else if (base_tick && fast_charge_select_i && low_current_select_i
                     && charge_pulse_width_select_i != CHARGE_SEL_UNUSED) begin
            charge_cnt_ff <= charge_len;
        end else if (run && charge_cnt_ff != '0) begin
            charge_cnt_ff <= charge_cnt_ff - 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // ladder and contrast
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ladder_select_o <= LADDER_OFF;
        end else if (!display_driver_on_i) begin
            ladder_select_o <= LADDER_OFF;
        end else if (!low_current_select_i || charge_cnt_ff != '0) begin
            ladder_select_o <= LADDER_LOWR;
        end else begin
            ladder_select_o <= LADDER_HIGHR;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            contrast_level_o <= CONTRAST_RESET;
        end else begin
            contrast_level_o <= contrast_step_select_i;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            base_tick_o    <= 1'b0;
            charge_pulse_o <= 1'b0;
        end else begin
            base_tick_o    <= base_tick;
            charge_pulse_o <= display_driver_on_i && charge_cnt_ff != '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // backplane levels: selected row swings vlcd/vlcd3, others vlcd1/vlcd2
    function automatic logic [1:0] bp_level(input logic sel, input logic h);
        if (sel) begin
            bp_level = h ? LVL_VLCD3 : LVL_VLCD;
        end else begin
            bp_level = h ? LVL_VLCD2 : LVL_VLCD1;
        end
    endfunction

    // segment on: frontplane opposite of selected backplane
    function automatic logic [1:0] fp_level(input logic on, input logic h,
                                            input logic stat);
        if (stat) begin
            fp_level = (on ^ h) ? LVL_VLCD3 : LVL_VLCD;
        end else if (on) begin
            fp_level = h ? LVL_VLCD : LVL_VLCD3;
        end else begin
            fp_level = h ? LVL_VLCD1 : LVL_VLCD2;
        end
    endfunction

    logic is_static;
    logic is_quarter;
    assign is_static  = (duty_select_i == DUTY_STATIC);
    assign is_quarter = (duty_select_i == DUTY_QUARTER);

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            backplane_out_0_o  <= LVL_VLCD;
            backplane_out_1_o  <= LVL_VLCD;
            backplane_out_2_o  <= LVL_VLCD;
            shared_plane_pin_o <= LVL_VLCD;
            frontplane_outputs_o[1:0] <= LVL_VLCD;
        end else if (!display_driver_on_i) begin
            backplane_out_0_o  <= LVL_VLCD;
            backplane_out_1_o  <= LVL_VLCD;
            backplane_out_2_o  <= LVL_VLCD;
            shared_plane_pin_o <= LVL_VLCD;
            frontplane_outputs_o[1:0] <= LVL_VLCD;
        end else begin
            backplane_out_0_o <= is_static ? (half_ff ? LVL_VLCD3 : LVL_VLCD)
                                 : bp_level(phase_ff == 2'h0, half_ff);
            backplane_out_1_o <= is_static ? LVL_VLCD
                                 : bp_level(phase_ff == 2'h1, half_ff);
            backplane_out_2_o <= is_static ? LVL_VLCD
                                 : bp_level(phase_ff == 2'h2, half_ff);
            shared_plane_pin_o <= is_quarter
                ? bp_level(phase_ff == 2'h3, half_ff)
                : fp_level(segment_bit_i[phase_ff], half_ff, is_static);
            // frontplane zero mirrors the shared pin, written here only
            frontplane_outputs_o[1:0] <= is_quarter
                ? bp_level(phase_ff == 2'h3, half_ff)
                : fp_level(segment_bit_i[phase_ff], half_ff, is_static);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // frontplanes 1..32, plus port ownership per pin

    genvar g;
    generate
        for (g = 0; g < NUM_FRONT; g++) begin : g_fp
            logic port_mode;
            if (g >= 11 && g <= 18) begin : g_pe
                assign port_mode = !porte_display_select_i;
            end else if (g >= 19 && g <= 22) begin : g_pcl
                assign port_mode = !portc_low_display_select_i;
            end else if (g >= 23 && g <= 26) begin : g_pch
                assign port_mode = !portc_high_display_select_i;
            end else begin : g_lcd
                assign port_mode = 1'b0;
            end
            assign frontplane_port_mode_o[g] = port_mode;
            if (g > 0) begin : g_drv
                always_ff @(posedge sys_clk_i or negedge rstn_i) begin
                    if (!rstn_i) begin
                        frontplane_outputs_o[2*g+1:2*g] <= LVL_VLCD;
                    end else if (!display_driver_on_i) begin
                        frontplane_outputs_o[2*g+1:2*g] <= LVL_VLCD;
                    end else begin
                        frontplane_outputs_o[2*g+1:2*g] <= fp_level(
                            segment_bit_i[4*g+phase_ff], half_ff, is_static);
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    a_off_blank: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        !display_driver_on_i |=> backplane_out_0_o == LVL_VLCD
        && ladder_select_o == LADDER_OFF)
        else $error("disabled driver not blank");
    a_static_bp1: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        is_static |=> backplane_out_1_o == LVL_VLCD)
        else $error("bp1 driven in static duty");
    a_low_ladder: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        display_driver_on_i && !low_current_select_i
        |=> ladder_select_o == LADDER_LOWR)
        else $error("ladder not low resistance");
    a_halt_hold: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        halted_ff && !wake_interrupt_i && display_driver_on_i
        |=> $stable(phase_ff))
        else $error("phase moved while halted");
    a_wake_run: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        wake_interrupt_i |=> !halted_ff)
        else $error("wake did not resume");
    a_phase_range: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        $stable(duty_select_i) && $past(phase_ff) <= $past(phase_last)
        |-> phase_ff <= phase_last)
        else $error("phase beyond frame");
    a_contrast_track: assert property (@(posedge sys_clk_i)
        disable iff (!rstn_i) ##1 contrast_level_o ==
        $past(contrast_step_select_i))
        else $error("contrast not tracked");
    a_base_steps: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        !base_tick && display_driver_on_i |=> $stable(half_ff))
        else $error("half phase moved without base tick");
endmodule // lcd_segment_waveform_timing
`default_nettype wire

/* testbench/lcd_panel_model.sv */
`timescale 1ns/100ps
`default_nettype none
module lcd_panel_model
    import lcd_timing_pkg::*;
(
    input  wire logic                   sys_clk_i,
    input  wire logic                   clear_i,
    input  wire logic [1:0]             bp0_i,
    input  wire logic [1:0]             bp1_i,
    input  wire logic [1:0]             bp2_i,
    input  wire logic [1:0]             bp3_i,
    input  wire logic [2*NUM_FRONT-1:0] front_i,
    output logic      [4*NUM_FRONT-1:0] lit_o
);
    logic [1:0] bp [4];
    assign bp[0] = bp0_i;
    assign bp[1] = bp1_i;
    assign bp[2] = bp2_i;
    assign bp[3] = bp3_i;
    // lit only on a full vlcd swing; bias steps alone leave it dark
    always_ff @(posedge sys_clk_i) begin
        for (int f = 0; f < NUM_FRONT; f++) begin
            for (int r = 0; r < 4; r++) begin
                if (clear_i) begin
                    lit_o[4*f+r] <= 1'b0;
                end else if ({bp[r], front_i[2*f +: 2]} == 4'h3 ||
                             {bp[r], front_i[2*f +: 2]} == 4'hc) begin
                    lit_o[4*f+r] <= 1'b1;
                end
            end
        end
    end
endmodule // lcd_panel_model
`default_nettype wire

/* testbench/test_lcd_segment_waveform_timing.sv */
`timescale 1ns/100ps
`default_nettype none
module test_lcd_segment_waveform_timing
    import lcd_timing_pkg::*;
;
    logic clk = 0, rst_n = 0, ref_tick = 0, drv_on = 0, low_cur = 0;
    logic fast_chg = 0, osc_keep = 0, stop = 0, wake = 0, clear = 0;
    logic pe_sel = 1, pcl_sel = 1, pch_sel = 1;
    logic [1:0] duty = 0, chg_sel = 0, bp0, bp1, bp2, shared, ladder;
    logic [2:0] div_sel = 0;
    logic [3:0] contrast = 0, contrast_lvl;
    logic [4*NUM_FRONT-1:0] seg = '0, lit;
    logic [2*NUM_FRONT-1:0] front;
    logic [NUM_FRONT-1:0]   port_mode;
    logic base_tick, chg_pulse;
    logic [31:0] lfsr = 32'hbc8a_94f8;
    logic [1:0] cur [4], prv [4];
    int mismatches = 0, checks_done = 0, n, chg [4], sh_err, run, best;
    always #50 clk = ~clk;
    lcd_segment_waveform_timing u_dut (
        .sys_clk_i                  (clk),
        .rstn_i                     (rst_n),
        .ref_tick_i                 (ref_tick),
        .display_driver_on_i        (drv_on),
        .duty_select_i              (duty),
        .base_divider_select_i      (div_sel),
        .low_current_select_i       (low_cur),
        .fast_charge_select_i       (fast_chg),
        .charge_pulse_width_select_i(chg_sel),
        .contrast_step_select_i     (contrast),
        .standby_oscillator_keep_i  (osc_keep),
        .stop_mode_i                (stop),
        .wake_interrupt_i           (wake),
        .porte_display_select_i     (pe_sel),
        .portc_low_display_select_i (pcl_sel),
        .portc_high_display_select_i(pch_sel),
        .segment_bit_i              (seg),
        .backplane_out_0_o          (bp0),
        .backplane_out_1_o          (bp1),
        .backplane_out_2_o          (bp2),
        .shared_plane_pin_o         (shared),
        .frontplane_outputs_o       (front),
        .frontplane_port_mode_o     (port_mode),
        .ladder_select_o            (ladder),
        .contrast_level_o           (contrast_lvl),
        .base_tick_o                (base_tick),
        .charge_pulse_o             (chg_pulse)
    );
    lcd_panel_model u_panel (.sys_clk_i(clk), .clear_i(clear), .bp0_i(bp0),
        .bp1_i(bp1), .bp2_i(bp2), .bp3_i(shared), .front_i(front),
        .lit_o(lit));
    ////////////////////////////////////////////////////////////////////////
    task automatic rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    endtask
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic wait_tick(input int lim);
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (base_tick !== 1'b1 && n < lim);
        if (base_tick !== 1'b1) begin
            mismatches++;
            close_out();
        end
    endtask
    task automatic count_ticks(input int cyc);
        n = 0;
        repeat (cyc) begin
            @(posedge clk);
            #1;
            if (base_tick === 1'b1) n++;
        end
    endtask
    task automatic watch(input int cyc);
        sh_err = 0;
        chg = '{default: 0};
        prv = '{bp0, bp1, bp2, shared};
        repeat (cyc) begin
            @(posedge clk);
            #1;
            cur = '{bp0, bp1, bp2, shared};
            for (int r = 0; r < 4; r++) if (cur[r] !== prv[r]) chg[r]++;
            prv = cur;
            if (shared !== front[1:0]) sh_err++;
        end
    endtask
    function automatic logic [32:0] exp_port(input logic [2:0] s);
        return {6'h00, {4{~s[0]}}, {4{~s[1]}}, {8{~s[2]}}, 11'h000};
    endfunction
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge clk);
        @(negedge clk) rst_n = 1;
        chk({bp0, bp1, bp2, shared, ladder, contrast_lvl, front}, 0);
        @(negedge clk) drv_on = 1;
        ref_tick = 1;
        for (int s = 0; s < 8; s++) begin
            @(negedge clk) div_sel = s[2:0];
            wait_tick(20000);
            wait_tick(20000);
            chk(n, 128 << s);
        end
        $display("divider test done");
        @(negedge clk) div_sel = 0;
        for (int d = 0; d < 3; d++) begin
            for (int k = 0; k < 5; k++) begin
                rnd();
                seg = {seg[99:0], lfsr};
            end
            seg[11:4] = 8'h0f;
            duty = d[1:0];
            repeat (1100) @(negedge clk);
            clear = 1;
            @(negedge clk) clear = 0;
            watch(2100);
            chk(chg[0] != 0, 1);
            chk(chg[1] != 0, d != 0);
            chk(chg[2] != 0, d == 2 || d == 1);
            if (d == 2) chk(chg[3] != 0, 1);
            else chk(sh_err, 0);
            for (int f = 1; f < NUM_FRONT; f++)
                for (int r = 0; r < (d == 0 ? 1 : d + 2); r++)
                    chk(lit[4*f+r], seg[4*f+r]);
            $display("duty %0d test done", d);
        end
        for (int i = 0; i < 8; i++) begin
            @(negedge clk) {pe_sel, pcl_sel, pch_sel} = i[2:0];
            #1 chk(port_mode, exp_port(i[2:0]));
        end
        {pe_sel, pcl_sel, pch_sel} = 3'h7;
        for (int k = 0; k < 4; k++) begin
            rnd();
            @(negedge clk) contrast = k == 0 ? 4'hf : lfsr[3:0];
            repeat (3) @(negedge clk);
            chk(contrast_lvl, contrast);
        end
        chk(ladder, LADDER_LOWR);
        @(negedge clk) low_cur = 1;
        repeat (3) @(negedge clk);
        chk(ladder, LADDER_HIGHR);
        fast_chg = 1;
        for (int f = 0; f < 4; f++) begin
            chg_sel = f[1:0];
            wait_tick(300);
            best = 0;
            run = 0;
            sh_err = 0;
            repeat (300) begin
                @(posedge clk);
                #1;
                run = ladder === LADDER_LOWR ? run + 1 : 0;
                if (run > best) best = run;
                if (chg_pulse !== (ladder === LADDER_LOWR)) sh_err++;
            end
            chk(best, f == 3 ? 0 : 128 >> (5 + f));
            chk(sh_err, 0);
        end
        $display("ladder test done");
        @(negedge clk) stop = 1;
        // a tick launched on the halting edge still shows one cycle later
        repeat (2) @(negedge clk);
        count_ticks(400);
        chk(n, 0);
        chk(contrast_lvl, contrast);
        @(negedge clk) wake = 1;
        stop = 0;
        @(negedge clk) wake = 0;
        wait_tick(300);
        @(negedge clk) osc_keep = 1;
        stop = 1;
        count_ticks(400);
        chk(n != 0, 1);
        @(negedge clk) stop = 0;
        drv_on = 0;
        repeat (3) @(negedge clk);
        chk({bp0, bp1, bp2, shared, ladder, front}, 0);
        $display("standby and disable test done");
        close_out();
    end
endmodule // test_lcd_segment_waveform_timing
`default_nettype wire
